// File: core/iid_top.sv
// Field input conditioner: synchronise, invert, debounce, APB registers.
// Assumes a zero-wait APB master on pclk and asynchronous field inputs.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`include "iid_map.svh"

module iid_top
    import iid_pkg::*;
#(
    parameter int unsigned N           = 8,
    parameter int unsigned AW          = 8,
    parameter int unsigned TICK_CYCLES = `IID_TICK_CYC
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Field side
    input  wire logic [N-1:0]  field_input,
    output logic [N-1:0]       field_state
);
    localparam int unsigned DW = N * `IID_DEB_FLD_W;

    // Synchroniser and accepted raw state
    logic [N-1:0] sync1_reg;
    logic [N-1:0] sync2_reg;
    logic [N-1:0] sync3_reg;
    logic [N-1:0] raw_reg;
    logic [N-1:0] raw_next;
    wire  [N-1:0] agree = ~(sync2_reg ^ sync3_reg);

    // Registers
    logic [N-1:0]  inv_reg;
    logic [N-1:0]  inv_next;
    logic [DW-1:0] deb_reg;
    logic [DW-1:0] deb_next;
    logic [N-1:0]  chg_reg;
    logic [N-1:0]  chg_next;
    logic [31:0]   prdata_reg;
    logic [31:0]   prdata_next;

    // Channel results
    logic [N-1:0] cond;
    logic [N-1:0] changed;
    logic         tick;

    // Address decode
    wire hit_inv   = (paddr == AW'(`IID_INV_OFS));
    wire hit_deb   = (paddr == AW'(`IID_DEB_OFS));
    wire hit_raw   = (paddr == AW'(`IID_RAW_OFS));
    wire hit_state = (paddr == AW'(`IID_STATE_OFS));
    wire hit_chg   = (paddr == AW'(`IID_CHG_OFS));
    wire hit_any   = hit_inv | hit_deb | hit_raw | hit_state | hit_chg;

    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire wr     = access & pwrite & pready;
    wire rd_cap = setup & ~pwrite;

    // Write strobes
    wire wr_inv = wr & hit_inv;
    wire wr_deb = wr & hit_deb;
    wire wr_chg = wr & hit_chg;

    // Zero wait states; unmapped address errors in the access phase
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;
    assign prdata  = prdata_reg;

    // Read mux, unused upper bits read as zero
    wire [31:0] rd_inv   = 32'(inv_reg);
    wire [31:0] rd_deb   = 32'(deb_reg);
    wire [31:0] rd_raw   = 32'(raw_reg);
    wire [31:0] rd_state = 32'(cond);
    wire [31:0] rd_chg   = 32'(chg_reg);

    assign prdata_next = rd_cap ?
        (({32{hit_inv}}   & rd_inv)   |
         ({32{hit_deb}}   & rd_deb)   |
         ({32{hit_raw}}   & rd_raw)   |
         ({32{hit_state}} & rd_state) |
         ({32{hit_chg}}   & rd_chg))
        : prdata_reg;

    assign inv_next = wr_inv ? pwdata[N-1:0] : inv_reg;
    assign deb_next = wr_deb ? pwdata[DW-1:0] : deb_reg;

    // Write one to clear; a new change in the same cycle wins
    assign chg_next = (chg_reg & ~({N{wr_chg}} & pwdata[N-1:0]))
                      | changed;

    // A bit is taken only once the last two stages agree
    assign raw_next = (sync3_reg & agree) | (raw_reg & ~agree);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            raw_reg   <= '0;
        end else begin
            sync1_reg <= field_input;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            raw_reg   <= raw_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_reg    <= N'(`IID_INV_RST);
            deb_reg    <= DW'(`IID_DEB_RST);
            chg_reg    <= N'(`IID_CHG_RST);
            prdata_reg <= 32'h0000_0000;
        end else begin
            inv_reg    <= inv_next;
            deb_reg    <= deb_next;
            chg_reg    <= chg_next;
            prdata_reg <= prdata_next;
        end
    end

    iid_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // One filter per input
    generate
        for (genvar i = 0; i < N; i++) begin : g_chan
            iid_chan_if ch ();

            assign ch.in_bit = raw_reg[i] ^ inv_reg[i];
            assign ch.sel    = iid_deb_t'(deb_reg[2*i +: 2]);
            assign ch.tick   = tick;
            assign cond[i]    = ch.out_bit;
            assign changed[i] = ch.changed;

            iid_filter u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .ch      (ch.filt)
            );
        end
    endgenerate

    assign field_state = cond;
endmodule // iid_top

// File: core/iid_map.svh
// Offsets, field layout, reset values and timing counts of the input
// conditioner. Assumes a 10 MHz pclk and byte addresses on APB.
`ifndef IID_MAP_SVH
`define IID_MAP_SVH

// Register byte offsets
`define IID_INV_OFS      8'h00
`define IID_DEB_OFS      8'h04
`define IID_RAW_OFS      8'h08
`define IID_STATE_OFS    8'h0C
`define IID_CHG_OFS      8'h10

// Reset values
`define IID_INV_RST      32'h0000_0000
`define IID_DEB_RST      32'h0000_0000
`define IID_CHG_RST      32'h0000_0000

// Debounce select field of input i sits at bits [2i+1:2i]
`define IID_DEB_FLD_W    2

// Debounce intervals in ms: 20, 50, 100
`define IID_DEB_20_MS    7'h14
`define IID_DEB_50_MS    7'h32
`define IID_DEB_100_MS   7'h64
`define IID_DEB_CNT_W    7

// Time base: 1000 us tick from a 10 MHz clock
`define IID_PCLK_HZ      32'h0098_9680
`define IID_TICK_US      32'h0000_03E8
`define IID_TICK_CYC     (`IID_TICK_US * (`IID_PCLK_HZ / 32'h000F_4240))

`endif

// File: core/iid_pkg.sv
// Types shared by the input conditioner modules.
// Assumes iid_map.svh is on the include path.
`include "iid_map.svh"

package iid_pkg;

    typedef enum logic [1:0] {
        IID_DEB_NONE = 2'h0,
        IID_DEB_20   = 2'h1,
        IID_DEB_50   = 2'h2,
        IID_DEB_100  = 2'h3
    } iid_deb_t;

    typedef enum logic {
        IID_ST_STABLE = 1'b0,
        IID_ST_PEND   = 1'b1
    } iid_flt_state_t;

    typedef logic [`IID_DEB_CNT_W-1:0] iid_cnt_t;

    function automatic iid_cnt_t iid_deb_limit(input iid_deb_t sel);
        iid_cnt_t lim;
        lim = '0;
        unique case (sel)
            IID_DEB_NONE: lim = '0;
            IID_DEB_20:   lim = `IID_DEB_20_MS;
            IID_DEB_50:   lim = `IID_DEB_50_MS;
            IID_DEB_100:  lim = `IID_DEB_100_MS;
        endcase
        return lim;
    endfunction

endpackage

// File: core/iid_chan_if.sv
// One input channel between the register side and its debounce filter.
// Assumes iid_pkg is compiled first.
interface iid_chan_if;
    import iid_pkg::*;

    logic     in_bit;
    iid_deb_t sel;
    logic     tick;
    logic     out_bit;
    logic     changed;

    modport filt (
        input  in_bit,
        input  sel,
        input  tick,
        output out_bit,
        output changed
    );

    modport ctrl (
        output in_bit,
        output sel,
        output tick,
        input  out_bit,
        input  changed
    );
endinterface

// File: core/iid_tick_gen.sv
// Free-running millisecond tick generator.
// Assumes pclk at the rate the cycle count was derived for.
`include "iid_map.svh"

module iid_tick_gen
    import iid_pkg::*;
#(
    parameter int unsigned CYCLES = `IID_TICK_CYC
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tick out
    output logic      tick
);
    localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_reg;
    wire           wrap = (cnt_reg == LAST);

    assign cnt_next = wrap ? '0 : cnt_reg + CW'(1);
    assign tick     = tick_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= wrap;
        end
    end
endmodule // iid_tick_gen

// File: core/iid_filter.sv
// Debounce filter for one conditioned input.
// Assumes in_bit is already synchronised and inverted, tick is 1 ms.
module iid_filter
    import iid_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Channel
    iid_chan_if.filt  ch
);
    iid_flt_state_t state_reg;
    iid_flt_state_t state_next;
    logic           out_reg;
    logic           out_next;
    iid_cnt_t       cnt_reg;
    iid_cnt_t       cnt_next;

    wire      differ = ch.in_bit ^ out_reg;
    wire      bypass = (ch.sel == IID_DEB_NONE);
    iid_cnt_t limit;
    assign limit = iid_deb_limit(ch.sel);

    // Accept on the tick after limit ticks: the first tick may land
    // right after the edge, so one extra tick guarantees the full time.
    wire expired = ch.tick && (cnt_reg >= limit);

    always_comb begin
        state_next = state_reg;
        out_next   = out_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            IID_ST_STABLE: begin
                cnt_next = '0;
                if (differ && bypass) begin
                    out_next = ch.in_bit;
                end else if (differ) begin
                    state_next = IID_ST_PEND;
                end
            end
            IID_ST_PEND: begin
                if (!differ) begin
                    state_next = IID_ST_STABLE;
                    cnt_next   = '0;
                end else if (bypass || expired) begin
                    out_next   = ch.in_bit;
                    state_next = IID_ST_STABLE;
                    cnt_next   = '0;
                end else if (ch.tick) begin
                    cnt_next = cnt_reg + iid_cnt_t'(1);
                end
            end
        endcase
    end

    assign ch.out_bit = out_reg;
    assign ch.changed = out_next ^ out_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IID_ST_STABLE;
            out_reg   <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            out_reg   <= out_next;
            cnt_reg   <= cnt_next;
        end
    end
endmodule // iid_filter

// File: tb/iid_top_asserts.sv
// Checker on the input conditioner ports, watching input 0.
// Assumes writes land at the APB access edge.
`include "iid_map.svh"

module iid_top_asserts #(
    parameter int unsigned N           = 8,
    parameter int unsigned AW          = 8,
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // APB
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Field side
    input wire logic [N-1:0]  field_input,
    input wire logic [N-1:0]  field_state
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [N-1:0] inv_sh;
    logic [1:0]   sel0;
    logic         lvl_q;
    logic [31:0]  run_cnt;
    wire          lvl = field_input[0] ^ inv_sh[0];
    wire          wr = psel && penable && pwrite && pready;
    // Shortest legal delay in cycles for the snooped interval
    wire [31:0]   lim = TICK_CYCLES * (sel0 == 2'h1 ? 32'h14 :
        sel0 == 2'h2 ? 32'h32 : sel0 == 2'h3 ? 32'h64 : 32'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_sh  <= '0;
            sel0    <= 2'h0;
            lvl_q   <= 1'b0;
            run_cnt <= 32'h0;
        end else begin
            if (wr && paddr == `IID_INV_OFS) inv_sh <= pwdata[N-1:0];
            if (wr && paddr == `IID_DEB_OFS) sel0 <= pwdata[1:0];
            lvl_q   <= lvl;
            run_cnt <= (lvl != lvl_q) ? 32'h0 : run_cnt + 32'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    reset_clear_a:
        assert property ($rose(presetn) |-> field_state == '0)
        else $error("state not clear after reset");
    early_change_a:
        assert property ($changed(field_state[0]) |-> run_cnt >= lim)
        else $error("state changed before interval ran out");
    change_value_a:
        assert property ($changed(field_state[0]) |-> field_state[0] == lvl)
        else $error("state changed to a value not at the input");
    late_accept_a:
        assert property (run_cnt == lim + TICK_CYCLES + 32'h8
            |-> field_state[0] == lvl)
        else $error("steady input not accepted in time");
    bypass_follow_a:
        assert property (sel0 == 2'h0 && $changed(lvl) ##1 $stable(lvl) [*6]
            |-> field_state[0] == lvl)
        else $error("unfiltered input not followed");
    access_ready_a:
        assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    unmapped_err_a:
        assert property (psel && penable && paddr > `IID_CHG_OFS |-> pslverr)
        else $error("unmapped access without error");
endmodule // iid_top_asserts

bind iid_top iid_top_asserts #(
    .N(N), .AW(AW), .TICK_CYCLES(TICK_CYCLES)
) iid_top_asserts_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .field_input, .field_state
);

// File: tb/iid_field_src.sv
// Field contact model driving the raw inputs.
// Assumes commands come just after a rising pclk edge.
module iid_field_src #(
    parameter int unsigned N = 8
) (
    // Clock
    input wire logic    pclk,
    // Contacts
    output logic [N-1:0] field_input
);
    timeunit 1ns;
    timeprecision 1ns;
    initial field_input = '0;
    // Masked contacts chatter once a cycle before settling
    task automatic put(input logic [N-1:0] m, input logic [N-1:0] v,
                       input int unsigned chatter);
        repeat (chatter) begin
            field_input <= field_input ^ m;
            @(posedge pclk);
        end
        field_input <= (field_input & ~m) | (v & m);
    endtask
endmodule // iid_field_src

// File: tb/iid_top_tb_top.sv
// Bench for the input conditioner: APB master, contacts, read checks.
// Assumes the checker is bound in; one ms is TICK pclk cycles here.
`include "iid_map.svh"

module iid_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TICK = 10;
    localparam int MS [4] = '{0, 20, 50, 100};
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, b = 1'b1;
    logic [7:0]  field_input, field_state, pins, inv;
    logic [31:0] dv;
    logic [32:0] exp_q[$];
    int          n_mismatch = 0, checks = 0, cyc = 0;
    int          seed = 32'h824A9427;

    always #50 pclk = ~pclk;

    iid_top #(.TICK_CYCLES(TICK)) iid_top_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .field_input, .field_state);
    iid_field_src #(.N(8)) iid_field_src_inst (.pclk, .field_input);

    task automatic check(input string what, input logic [32:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge: no double drive of psel, reader sees the last access
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (exp_q.size() == 0) check("read queue", 33'h0, 33'h1);
            else check("read", {pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        wt(5);
        presetn <= 1'b1;
        wt(1);
        rd(`IID_INV_OFS, 33'h0);
        rd(`IID_DEB_OFS, 33'h0);
        rd(`IID_CHG_OFS, 33'h0);
        rd(8'h14, {1'b1, 32'h0});
        iid_field_src_inst.put(8'h01, 8'h01, 0);
        wt(8);
        rd(`IID_STATE_OFS, 33'h1);
        apb(1'b1, `IID_INV_OFS, 32'h1);
        wt(3);
        rd(`IID_STATE_OFS, 33'h0);
        rd(`IID_CHG_OFS, 33'h1);
        apb(1'b1, `IID_CHG_OFS, 32'h1);
        rd(`IID_CHG_OFS, 33'h0);
        apb(1'b1, `IID_INV_OFS, 32'h0);
        wt(8);
        for (int s = 1; s < 4; s++) begin
            apb(1'b1, `IID_DEB_OFS, 32'(s));
            rd(`IID_DEB_OFS, 33'(s));
            b = ~b;
            iid_field_src_inst.put(8'h01, {7'h0, b}, 4);
            wt(MS[s] * TICK - 10);
            rd(`IID_STATE_OFS, {32'h0, ~b});
            wt(30);
            rd(`IID_STATE_OFS, {32'h0, b});
        end
        apb(1'b1, `IID_DEB_OFS, 32'h1);
        iid_field_src_inst.put(8'h01, {7'h0, ~b}, 0);
        wt(150);
        iid_field_src_inst.put(8'h01, {7'h0, b}, 0);
        wt(10);
        rd(`IID_STATE_OFS, {32'h0, b});
        iid_field_src_inst.put(8'h01, {7'h0, ~b}, 0);
        wt(150);
        rd(`IID_STATE_OFS, {32'h0, b});
        wt(80);
        rd(`IID_STATE_OFS, {32'h0, ~b});
        repeat (4) begin
            pins = 8'($random(seed));
            inv = 8'($random(seed));
            dv = 32'($random(seed)) | 32'h1;
            apb(1'b1, `IID_DEB_OFS, dv);
            rd(`IID_DEB_OFS, {17'h0, dv[15:0]});
            apb(1'b1, `IID_DEB_OFS, 32'h0);
            apb(1'b1, `IID_INV_OFS, {24'h0, inv});
            wt(8);
            iid_field_src_inst.put(8'hFF, pins, 0);
            wt(8);
            apb(1'b1, `IID_RAW_OFS, 32'hFFFFFFFF);
            rd(`IID_RAW_OFS, 33'(pins));
            rd(`IID_INV_OFS, 33'(inv));
            rd(`IID_STATE_OFS, 33'(pins ^ inv));
        end
        apb(1'b1, `IID_CHG_OFS, 32'hFFFFFFFF);
        rd(`IID_CHG_OFS, 33'h0);
        check("reads left", 33'(exp_q.size()), 33'h0);
        summarize();
    end
endmodule // iid_top_tb_top
